//--- src/acs_pkg.sv
// constants of the autoscan converter sequencer
// What this block does
// - control bit selects continuous mode when set, single mode when clear
// - channels convert in turn from the start channel up to channel 7
// - start channel 7 converts only 7; start 3 converts 3 to 7
// - setting the run bit, by software or trigger, starts the scan
// - single mode clears the run bit after channel 7 and flags end
// - continuous mode restarts at the start channel until software stops it
// - every channel 7 completion raises an end of conversion request
// - each result overwrites its channel data register
// - pin and timer triggers are each gated by an enable, then ORed
// - continuous mode ignores all triggers after the starting one
// - triggers arriving while the run bit is set are ignored
// - channels 6 and 7 in range when below upper and at or above lower
// - out of range sets watchdog request and one of four top flags
// - four writable threshold registers at local addresses f8h to fbh
// - compare flags clear at reset and when watchdog pending is cleared
// - analog power bit clears at reset and on entry to halt
// - out of range sets watchdog pending, bit 6 of interrupt control
// - watchdog request is served before a simultaneous end of conversion
// - software clears pending flags; writing one raises a request
// - any control register write aborts the sequencer; it restarts only if the run bit is written
package acs_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] CHANNEL0_RESULT = 8'hf0;
	localparam logic [7:0] CHANNEL1_RESULT = 8'hf1;
	localparam logic [7:0] CHANNEL2_RESULT = 8'hf2;
	localparam logic [7:0] LOWER6_THRESHOLD = 8'hf8;
	localparam logic [7:0] LOWER7_THRESHOLD = 8'hf9;
	localparam logic [7:0] UPPER6_THRESHOLD = 8'hfa;
	localparam logic [7:0] UPPER7_THRESHOLD = 8'hfb;
	localparam logic [7:0] COMPARE_RESULT_REG = 8'hfc;
	localparam logic [7:0] CONTROL_LOGIC_REG = 8'hfd;
	localparam logic [7:0] INTERRUPT_CONTROL_REG = 8'hfe;
	localparam logic [7:0] INTERRUPT_VECTOR_REG = 8'hff;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CLR_RUN = 0;
	localparam int CLR_CONT = 1;
	localparam int CLR_POWER = 2;
	localparam int CLR_INT_EN = 3;
	localparam int CLR_EXT_EN = 4;
	localparam int CLR_SC_LSB = 5;
	localparam int ICR_EOC_MASK = 4;
	localparam int ICR_WD_MASK = 5;
	localparam int ICR_WD_PEND = 6;
	localparam int ICR_EOC_PEND = 7;
	localparam int IVR_SRC = 1;
	// ----------------------------------------------------------------
	// reset values and timing
	// ----------------------------------------------------------------
	localparam logic [7:0] CLR_RESET = 8'h00;
	localparam logic [2:0] PRESCALE_RESET = 3'h7;
	localparam logic [2:0] LAST_CHANNEL = 3'h7;
	localparam logic [2:0] WATCH_CHANNEL_A = 3'h6;
	localparam int CONV_BASE_CYCLES = 138;
	typedef enum logic {ACS_IDLE, ACS_CONVERT} acs_state_t;
endpackage : acs_pkg

//--- src/acs_sequencer.sv
// autoscan sequencer, watchdog compare and interrupt flags of an 8-bit converter
`timescale 1ns/100ps
module acs_sequencer #(
	parameter int DATA_W = 8,
	parameter int CONV_BASE = acs_pkg::CONV_BASE_CYCLES
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// register port
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rd_data_out,
	// triggers and system
	input wire logic ext_trigger_pin_in,
	input wire logic timer_trigger_in,
	input wire logic halt_in,
	// analog converter
	input wire logic [DATA_W-1:0] conv_result_in,
	output logic [2:0] channel_sel_out,
	output logic converting_out,
	output logic analog_power_on_out,
	// interrupt request to the core
	output logic irq_req_out,
	output logic irq_watchdog_out
);
	if (DATA_W != 8 || CONV_BASE < 1 || CONV_BASE > 255)
	begin : g_bad_param
		$error("acs_sequencer: unsupported parameters");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0] result_reg [0:7];
	logic [7:0] lower6, lower7, upper6, upper7;
	logic [3:0] cmp_flags;
	logic [2:0] prescale;
	logic [2:0] start_channel;
	logic ext_trigger_en, int_trigger_en, continuous_select, conversion_run;
	logic end_conv_pending, watchdog_pending, eoc_mask, wd_mask;
	logic [3:0] icr_low;
	logic [4:0] vector_base;
	logic [2:0] chan;
	logic [11:0] conv_cnt;
	logic ext_prev, tmr_prev;
	logic [7:0] next_rd;
	acs_pkg::acs_state_t state;

	// ----------------------------------------------------------------
	// decode and events
	// ----------------------------------------------------------------
	logic clr_wr, icr_wr, crr_wr, wr_run;
	logic trig, start, done, done_last;
	logic over6, under6, over7, under7, wd_event;
	logic [11:0] conv_len;

	function automatic logic [4:0] fdf(input logic [2:0] pr);
		unique case (pr)
			3'h7: fdf = 5'h01;
			3'h6: fdf = 5'h04;
			3'h5: fdf = 5'h06;
			3'h4: fdf = 5'h08;
			3'h3: fdf = 5'h0a;
			3'h2: fdf = 5'h0c;
			3'h1: fdf = 5'h0e;
			3'h0: fdf = 5'h10;
		endcase
	endfunction : fdf

	assign clr_wr = wr_in && addr_in == acs_pkg::CONTROL_LOGIC_REG;
	assign icr_wr = wr_in && addr_in == acs_pkg::INTERRUPT_CONTROL_REG;
	assign crr_wr = wr_in && addr_in == acs_pkg::COMPARE_RESULT_REG;
	assign wr_run = wr_data_in[acs_pkg::CLR_RUN];
	assign conv_len = 12'(CONV_BASE) * {7'h00, fdf(prescale)};
	// gated sources ORed; edge on rising side after a low level
	assign trig = (ext_trigger_en && ext_trigger_pin_in && !ext_prev)
		|| (int_trigger_en && timer_trigger_in && !tmr_prev);
	// a trigger only starts an idle sequencer
	assign start = trig && !conversion_run && !clr_wr;
	assign done = state == acs_pkg::ACS_CONVERT && conv_cnt == conv_len - 12'h001;
	assign done_last = done && chan == acs_pkg::LAST_CHANNEL;
	// window compare on channels 6 and 7
	assign over6 = conv_result_in >= upper6;
	assign under6 = conv_result_in < lower6;
	assign over7 = conv_result_in >= upper7;
	assign under7 = conv_result_in < lower7;
	assign wd_event = done && chan[2:1] == 2'b11
		&& (chan[0] ? (over7 || under7) : (over6 || under6));

	// ----------------------------------------------------------------
	// trigger edge history
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			ext_prev <= 1'b1;
			tmr_prev <= 1'b1;
		end
		else
		begin
			ext_prev <= ext_trigger_pin_in;
			tmr_prev <= timer_trigger_in;
		end
	end

	// ----------------------------------------------------------------
	// control logic register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			start_channel <= acs_pkg::CLR_RESET[7:5];
			ext_trigger_en <= 1'b0;
			int_trigger_en <= 1'b0;
			continuous_select <= 1'b0;
			analog_power_on_out <= 1'b0;
		end
		else
		begin
			if (clr_wr)
			begin
				start_channel <= wr_data_in[7:5];
				ext_trigger_en <= wr_data_in[acs_pkg::CLR_EXT_EN];
				int_trigger_en <= wr_data_in[acs_pkg::CLR_INT_EN];
				continuous_select <= wr_data_in[acs_pkg::CLR_CONT];
				analog_power_on_out <= wr_data_in[acs_pkg::CLR_POWER];
			end
			if (halt_in)
				analog_power_on_out <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			state <= acs_pkg::ACS_IDLE;
			conversion_run <= 1'b0;
			chan <= 3'h0;
			conv_cnt <= 12'h000;
		end
		else if (clr_wr)
		begin
			// abort; restart from the written start channel only if the run bit is written
			conv_cnt <= 12'h000;
			chan <= wr_data_in[7:5];
			conversion_run <= wr_run;
			state <= wr_run ? acs_pkg::ACS_CONVERT : acs_pkg::ACS_IDLE;
		end
		else
		begin
			unique case (state)
				acs_pkg::ACS_IDLE:
				begin
					conv_cnt <= 12'h000;
					if (start)
					begin
						conversion_run <= 1'b1;
						chan <= start_channel;
						state <= acs_pkg::ACS_CONVERT;
					end
				end
				acs_pkg::ACS_CONVERT:
				begin
					conv_cnt <= done ? 12'h000 : conv_cnt + 12'h001;
					if (done_last && continuous_select)
						chan <= start_channel;
					else if (done_last)
					begin
						conversion_run <= 1'b0;
						state <= acs_pkg::ACS_IDLE;
					end
					else if (done)
						chan <= chan + 3'h1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// result and threshold registers
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_result
			always_ff @(posedge clk_in)
			begin
				if (!rst_b_in)
					result_reg[gi] <= 8'h00;
				else if (done && chan == 3'(gi))
					result_reg[gi] <= conv_result_in;
				else if (wr_in && addr_in == acs_pkg::CHANNEL0_RESULT + 8'(gi))
					result_reg[gi] <= wr_data_in;
			end
		end
	endgenerate

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			lower6 <= 8'h00;
			lower7 <= 8'h00;
			upper6 <= 8'hff;
			upper7 <= 8'hff;
		end
		else if (wr_in)
		begin
			if (addr_in == acs_pkg::LOWER6_THRESHOLD)
				lower6 <= wr_data_in;
			if (addr_in == acs_pkg::LOWER7_THRESHOLD)
				lower7 <= wr_data_in;
			if (addr_in == acs_pkg::UPPER6_THRESHOLD)
				upper6 <= wr_data_in;
			if (addr_in == acs_pkg::UPPER7_THRESHOLD)
				upper7 <= wr_data_in;
		end
	end

	// ----------------------------------------------------------------
	// compare flags and prescaler
	// ----------------------------------------------------------------
	logic [3:0] new_flags;
	assign new_flags = done ? {over7 && chan == 3'h7, over6 && chan == 3'h6,
		under7 && chan == 3'h7, under6 && chan == 3'h6} : 4'h0;

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			cmp_flags <= 4'h0;
			prescale <= acs_pkg::PRESCALE_RESET;
		end
		else
		begin
			if (crr_wr)
				prescale <= wr_data_in[2:0];
			// new flags win over any clear in the same cycle
			if (icr_wr && !wr_data_in[acs_pkg::ICR_WD_PEND])
				cmp_flags <= new_flags;
			else if (crr_wr)
				cmp_flags <= wr_data_in[7:4] | new_flags;
			else
				cmp_flags <= cmp_flags | new_flags;
		end
	end

	// ----------------------------------------------------------------
	// interrupt control and vector
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			end_conv_pending <= 1'b0;
			watchdog_pending <= 1'b0;
			eoc_mask <= 1'b0;
			wd_mask <= 1'b0;
			icr_low <= 4'h0;
			vector_base <= 5'h00;
		end
		else
		begin
			if (icr_wr)
			begin
				eoc_mask <= wr_data_in[acs_pkg::ICR_EOC_MASK];
				wd_mask <= wr_data_in[acs_pkg::ICR_WD_MASK];
				icr_low <= wr_data_in[3:0];
			end
			if (wr_in && addr_in == acs_pkg::INTERRUPT_VECTOR_REG)
				vector_base <= wr_data_in[7:3];
			// software may write ones; hardware set wins over clear
			end_conv_pending <= done_last
				|| (icr_wr ? wr_data_in[acs_pkg::ICR_EOC_PEND] : end_conv_pending);
			watchdog_pending <= wd_event
				|| (icr_wr ? wr_data_in[acs_pkg::ICR_WD_PEND] : watchdog_pending);
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			irq_req_out <= 1'b0;
			irq_watchdog_out <= 1'b0;
		end
		else
		begin
			irq_req_out <= (watchdog_pending && wd_mask) || (end_conv_pending && eoc_mask);
			// watchdog first, end of conversion stays pending
			irq_watchdog_out <= watchdog_pending && wd_mask;
		end
	end

	// ----------------------------------------------------------------
	// converter outputs and read port
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			channel_sel_out <= 3'h0;
			converting_out <= 1'b0;
		end
		else
		begin
			channel_sel_out <= chan;
			converting_out <= state == acs_pkg::ACS_CONVERT;
		end
	end

	always_comb
	begin
		next_rd = 8'h00;
		if (addr_in[7:3] == acs_pkg::CHANNEL0_RESULT[7:3])
			next_rd = result_reg[addr_in[2:0]];
		else
		begin
			unique case (addr_in)
				acs_pkg::LOWER6_THRESHOLD: next_rd = lower6;
				acs_pkg::LOWER7_THRESHOLD: next_rd = lower7;
				acs_pkg::UPPER6_THRESHOLD: next_rd = upper6;
				acs_pkg::UPPER7_THRESHOLD: next_rd = upper7;
				acs_pkg::COMPARE_RESULT_REG: next_rd = {cmp_flags, 1'b1, prescale};
				acs_pkg::CONTROL_LOGIC_REG: next_rd = {start_channel, ext_trigger_en,
					int_trigger_en, analog_power_on_out, continuous_select, conversion_run};
				acs_pkg::INTERRUPT_CONTROL_REG: next_rd = {end_conv_pending,
					watchdog_pending, wd_mask, eoc_mask, icr_low};
				acs_pkg::INTERRUPT_VECTOR_REG: next_rd = {vector_base, 1'b0,
					!(watchdog_pending && wd_mask), 1'b0};
				default: next_rd = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
			rd_data_out <= 8'h00;
		else if (rd_in)
			rd_data_out <= next_rd;
		else
			rd_data_out <= 8'h00;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	single_stop_a: assert property (done_last && !continuous_select && !clr_wr
		|=> !conversion_run && state == acs_pkg::ACS_IDLE)
		else $error("single scan did not stop after channel 7");
	cont_restart_a: assert property (done_last && continuous_select && !clr_wr
		|=> conversion_run && chan == $past(start_channel))
		else $error("continuous scan did not restart at start channel");
	eoc_flag_a: assert property (done_last |=> end_conv_pending)
		else $error("end of conversion not flagged");
	chan_step_a: assert property (done && chan != 3'h7 && !clr_wr
		|=> chan == $past(chan) + 3'h1)
		else $error("channel did not advance");
	trig_ignore_a: assert property (conversion_run && trig && !done && !clr_wr
		|=> $stable(chan) && conversion_run)
		else $error("trigger disturbed a running scan");
	wd_pending_a: assert property (wd_event |=> watchdog_pending && cmp_flags != 4'h0)
		else $error("watchdog event not flagged");
	flag_clear_a: assert property (icr_wr && !wr_data_in[6] && !wd_event
		|=> cmp_flags == 4'h0)
		else $error("compare flags not cleared");
	halt_power_a: assert property (halt_in |=> !analog_power_on_out)
		else $error("analog power stayed on in halt");
	result_store_a: assert property (done && !clr_wr
		|=> result_reg[$past(chan)] == $past(conv_result_in))
		else $error("result not stored");
	irq_prio_a: assert property (watchdog_pending && wd_mask
		|=> irq_req_out && irq_watchdog_out)
		else $error("watchdog request not served first");
	abort_a: assert property (clr_wr |=> conv_cnt == 12'h000
		&& chan == $past(wr_data_in[7:5]))
		else $error("control write did not reinitialise");
endmodule : acs_sequencer

//--- bench/acs_far_model.sv
// converter input, trigger pin and timer event stand-in for the sequencer bench
`timescale 1ns/100ps
module acs_far_model (
	// clock
	input wire logic clk_in,
	// converter side
	input wire logic [2:0] channel_sel_in,
	input wire logic converting_in,
	input wire logic [63:0] level_in,
	output logic [7:0] conv_result_out,
	// trigger requests from the bench
	input wire logic fire_ext_in,
	input wire logic fire_tmr_in,
	output logic ext_trigger_pin_out,
	output logic timer_trigger_out
);
	logic [7:0] last = 8'h00;
	logic [1:0] ext_cnt = 2'h0;
	logic [1:0] tmr_cnt = 2'h0;
	// ----------------------------------------------------------------
	// analog inputs
	// ----------------------------------------------------------------
	// outside a conversion the result lines carry nothing worth sampling
	always_comb
	begin
		if (converting_in)
			conv_result_out = level_in[channel_sel_in * 8 +: 8];
		else
			conv_result_out = ~last;
	end
	always @(posedge clk_in)
	begin
		if (converting_in)
			last <= conv_result_out;
	end
	// ----------------------------------------------------------------
	// trigger sources
	// ----------------------------------------------------------------
	// pulses are two cycles high and rest low between requests
	always @(posedge clk_in)
	begin
		if (fire_ext_in)
			ext_cnt <= 2'h2;
		else if (ext_cnt != 2'h0)
			ext_cnt <= ext_cnt - 2'h1;
		if (fire_tmr_in)
			tmr_cnt <= 2'h2;
		else if (tmr_cnt != 2'h0)
			tmr_cnt <= tmr_cnt - 2'h1;
	end
	assign ext_trigger_pin_out = (ext_cnt != 2'h0);
	assign timer_trigger_out = (tmr_cnt != 2'h0);
endmodule : acs_far_model

//--- bench/testbench.sv
// self-checking bench for the autoscan converter sequencer
`timescale 1ns/100ps
module testbench;
	localparam logic [7:0] CTL = acs_pkg::CONTROL_LOGIC_REG;
	localparam logic [7:0] ICA = acs_pkg::INTERRUPT_CONTROL_REG;
	localparam logic [7:0] CMP = acs_pkg::COMPARE_RESULT_REG;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [7:0] addr_in = 8'h00;
	logic [7:0] wr_data_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic halt_in = 1'b0;
	logic fire_ext = 1'b0;
	logic fire_tmr = 1'b0;
	logic rd_seen = 1'b0;
	logic [63:0] level = 64'h0;
	logic [7:0] rd_data_out, conv_result_in;
	logic [2:0] channel_sel_out;
	logic converting_out, analog_power_on_out, irq_req_out, irq_watchdog_out, ext_pin, tmr_pin;
	logic [7:0] exp_q[$];
	logic [7:0] ra[9] = '{8'hfd, 8'hfc, 8'hf8, 8'hf9, 8'hfa, 8'hfb, 8'hfe, 8'hf0, 8'h10};
	logic [7:0] rv[9] = '{8'h00, 8'h0f, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
	logic [7:0] w6[3] = '{8'h3f, 8'h40, 8'hff};
	logic [7:0] w7[3] = '{8'h80, 8'h7f, 8'h1f};
	logic [7:0] wc[3] = '{8'h9f, 8'h0f, 8'h6f};
	logic wd[3] = '{1'b1, 1'b0, 1'b1};
	int failures = 0;
	int checks = 0;
	int seed = 32'h5c86;
	int i;
	always #20 clk_in = ~clk_in;
	acs_sequencer #(.CONV_BASE(4)) dut_u (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
		.wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
		.ext_trigger_pin_in(ext_pin), .timer_trigger_in(tmr_pin), .halt_in(halt_in),
		.conv_result_in(conv_result_in), .channel_sel_out(channel_sel_out),
		.converting_out(converting_out), .analog_power_on_out(analog_power_on_out),
		.irq_req_out(irq_req_out), .irq_watchdog_out(irq_watchdog_out));
	acs_far_model far_u (
		.clk_in(clk_in), .channel_sel_in(channel_sel_out), .converting_in(converting_out),
		.level_in(level), .conv_result_out(conv_result_in), .fire_ext_in(fire_ext),
		.fire_tmr_in(fire_tmr), .ext_trigger_pin_out(ext_pin), .timer_trigger_out(tmr_pin));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic close_out;
		if (failures == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
	endtask : rd
	task automatic settle(input int n);
		repeat (n) @(posedge clk_in);
		@(negedge clk_in);
	endtask : settle
	task automatic fire(input logic ext);
		@(posedge clk_in);
		fire_ext <= ext;
		fire_tmr <= ~ext;
		@(posedge clk_in);
		fire_ext <= 1'b0;
		fire_tmr <= 1'b0;
	endtask : fire
	task automatic wait_irq;
		int n;
		n = 0;
		settle(1);
		while (irq_req_out !== 1'b1 && n < 400)
		begin
			@(negedge clk_in);
			n++;
		end
		check({7'h0, irq_req_out}, 8'h01);
	endtask : wait_irq
	// ----------------------------------------------------------------
	// read data watcher
	// ----------------------------------------------------------------
	always @(posedge clk_in)
		rd_seen <= rd_in;
	always @(negedge clk_in)
	begin
		if (rd_seen)
			check(rd_data_out, exp_q.pop_front());
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge clk_in);
		rst_b_in <= 1'b1;
		for (i = 0; i < 9; i++)
			rd(ra[i], rv[i]);
		wr(8'hf0, 8'h5a);
		rd(8'hf0, 8'h5a);
		wr(CTL, 8'h04);
		settle(2);
		check({7'h0, analog_power_on_out}, 8'h01);
		@(posedge clk_in);
		halt_in <= 1'b1;
		@(posedge clk_in);
		halt_in <= 1'b0;
		settle(2);
		check({7'h0, analog_power_on_out}, 8'h00);
		wr(CTL, 8'h04);
		repeat (1500) @(posedge clk_in);
		level <= {$random(seed), $random(seed)} & 64'h7f7f7f7f7f7f7f7f;
		wr(ICA, 8'h10);
		wr(CTL, 8'h65);
		wait_irq;
		for (i = 3; i < 8; i++)
			rd(8'hf0 + i[7:0], level[i * 8 +: 8]);
		rd(8'hf1, 8'h00);
		rd(8'hf2, 8'h00);
		rd(CTL, 8'h64);
		rd(ICA, 8'h90);
		wr(ICA, 8'h10);
		wr(CTL, 8'h2c);
		fire(1'b1);
		settle(20);
		check({7'h0, converting_out}, 8'h00);
		fire(1'b0);
		wait_irq;
		rd(8'hf1, level[15:8]);
		rd(CTL, 8'h2c);
		wr(ICA, 8'h10);
		settle(40);
		check({7'h0, irq_req_out}, 8'h00);
		wr(CTL, 8'hf6);
		fire(1'b1);
		wait_irq;
		fire(1'b1);
		@(posedge clk_in);
		level[63:56] <= 8'h33;
		repeat (3)
		begin
			wr(ICA, 8'h10);
			wait_irq;
		end
		rd(8'hf7, 8'h33);
		fire(1'b1);
		wr(CTL, 8'hf6);
		settle(2);
		check({7'h0, converting_out}, 8'h00);
		rd(CTL, 8'hf6);
		wr(ICA, 8'h10);
		wr(8'hf8, 8'h40);
		wr(8'hf9, 8'h20);
		wr(8'hfb, 8'h80);
		for (i = 0; i < 3; i++)
		begin
			@(posedge clk_in);
			level[63:48] <= {w7[i], w6[i]};
			wr(CTL, 8'hc5);
			wait_irq;
			rd(CMP, wc[i]);
			rd(ICA, {1'b1, wd[i], 6'h10});
			wr(ICA, {1'b1, wd[i], 6'h30});
			settle(2);
			check({7'h0, irq_watchdog_out}, {7'h0, wd[i]});
			rd(acs_pkg::INTERRUPT_VECTOR_REG, {6'h0, ~wd[i], 1'b0});
			wr(ICA, 8'hb0);
			rd(CMP, 8'h0f);
			wr(ICA, 8'h10);
		end
		wr(ICA, 8'h60);
		settle(2);
		check({6'h0, irq_req_out, irq_watchdog_out}, 8'h03);
		wr(ICA, 8'h00);
		settle(2);
		check({7'h0, irq_req_out}, 8'h00);
		close_out;
	end
	initial
	begin
		repeat (6000) @(posedge clk_in);
		failures++;
		close_out;
	end
endmodule : testbench
